// >>> logic/spic_map.svh
// Register indices, field positions, reset values and timing counts of the SPI control block.
// Assumes inclusion by bare name from the package and the main module.
`ifndef SPIC_MAP_SVH
`define SPIC_MAP_SVH

// Register indices; byte address is four times the index
`define SPIC_IDX_CTRL        10'h0F3
`define SPIC_IDX_STAT        10'h0F4
`define SPIC_IDX_DATA        10'h0F5
`define SPIC_IDX_PAGE        10'h0F7

// APB address width in bits
`define SPIC_ADDR_W          12

// spi_control fields
`define SPIC_SELECT_OE_BIT   7
`define SPIC_UNIT_EN_BIT     6
`define SPIC_LOW_FIRST_BIT   5
`define SPIC_MASTER_BIT      4
`define SPIC_IDLE_POL_BIT    3
`define SPIC_PHASE_BIT       2

// Status fields
`define SPIC_DONE_BIT        7
`define SPIC_WCOL_BIT        6
`define SPIC_OVF_BIT         5
`define SPIC_FAULT_BIT       4
`define SPIC_FAULT_DIS_BIT   3

// Reset values
`define SPIC_CTRL_RST        8'h00
`define SPIC_INTERVAL_RST    2'h0
`define SPIC_DATA_RST        8'h00

// System clocks per serial clock half period
`define SPIC_SCK_HALF        4
// Index of the last serial clock edge of a byte (sixteen edges per byte)
`define SPIC_EDGES_LAST      5'h0F

`endif

// >>> logic/spic_pkg.sv
// Types shared by the SPI control block.
// Assumes the map header is on the include path.
`include "spic_map.svh"

package spic_pkg;

  typedef enum logic [1:0] {
    MST_IDLE,
    MST_SHIFT,
    MST_FINISH
  } spic_state_t;

  typedef logic [`SPIC_ADDR_W-3:0] spic_index_t;

endpackage

// >>> logic/spic_sync.sv
// Two-flop level synchroniser, one per bit.
// Assumes inputs are asynchronous to clock and change slower than it.
`timescale 1ns/1ps

module spic_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // Levels
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
          stage1_q[i] <= 1'b0;
          syncOut[i]  <= 1'b0;
        end else begin
          stage1_q[i] <= asyncIn[i];
          syncOut[i]  <= stage1_q[i];
        end
      end
    end
  endgenerate

endmodule

// >>> logic/spic_control_config.sv
// SPI control and configuration unit with an APB register port and SPI pins.
// Assumes linkClock is the serial clock pin input, used only in slave role; config is changed only while idle.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "spic_map.svh"

module spic_control_config #(
  parameter int SCK_HALF = `SPIC_SCK_HALF
) (
  // Clock and reset
  input  wire logic                    clock,
  input  wire logic                    reset,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [`SPIC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Serial clock pin
  input  wire logic                    linkClock,
  output logic                         sckOut,
  output logic                         sckOe,
  // Data pins
  input  wire logic                    mosiIn,
  output logic                         mosiOut,
  output logic                         mosiOe,
  input  wire logic                    misoIn,
  output logic                         misoOut,
  output logic                         misoOe,
  // Slave select pin, active low
  input  wire logic                    ssNIn,
  output logic                         ssNOut,
  output logic                         ssNOe
);

  // Registers
  logic [7:0]                ctrl_q;
  logic [1:0]                interval_q;
  logic                      page_q;
  logic                      done_q;
  logic                      wcol_q;
  logic                      ovf_q;
  logic                      fault_q;
  logic                      faultDis_q;
  logic [7:0]                rxBuf_q;
  logic [7:0]                txByte_q;
  logic [31:0]               rdData_q;
  logic                      err_q;

  // Master engine
  spic_pkg::spic_state_t     state_q;
  logic [$clog2(SCK_HALF+1)-1:0] div_q;
  logic [4:0]                edge_q;
  logic [2:0]                outIdx_q;
  logic [7:0]                mRx_q;
  logic                      sck_q;
  logic                      mosi_q;
  logic                      ssN_q;

  // Crossing and slave side
  logic [2:0]                syncOut;
  logic                      misoS;
  logic                      ssNS;
  logic                      doneTogS;
  logic                      doneSeen_q;
  logic [2:0]                sCount_l;
  logic [7:0]                sRx_l;
  logic [7:0]                sByte_l;
  logic                      doneTog_l;

  // Configuration views
  logic enabled, master, lowFirst, idlePol, phase, selectOe;
  assign enabled  = ctrl_q[`SPIC_UNIT_EN_BIT];
  assign master   = ctrl_q[`SPIC_MASTER_BIT];
  assign lowFirst = ctrl_q[`SPIC_LOW_FIRST_BIT];
  assign idlePol  = ctrl_q[`SPIC_IDLE_POL_BIT];
  assign phase    = ctrl_q[`SPIC_PHASE_BIT];
  assign selectOe = ctrl_q[`SPIC_SELECT_OE_BIT];

  function automatic logic pickBit(input logic [7:0] b, input logic [2:0] i, input logic lsb);
    pickBit = lsb ? b[i] : b[3'(3'd7 - i)];
  endfunction

  function automatic logic [7:0] shiftIn(input logic [7:0] b, input logic d, input logic lsb);
    shiftIn = lsb ? {d, b[7:1]} : {b[6:0], d};
  endfunction

  // APB decode
  spic_pkg::spic_index_t idx;
  logic setup, access, aligned, mapped, wrAcc;
  logic wrCtrl, wrInterval, wrStat, wrData, wrPage;
  assign idx     = paddr[`SPIC_ADDR_W-1:2];
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign aligned = (paddr[1:0] == 2'h0);
  assign mapped  = aligned & ((idx == `SPIC_IDX_CTRL) | (idx == `SPIC_IDX_STAT) |
                              (idx == `SPIC_IDX_DATA) | (idx == `SPIC_IDX_PAGE));
  assign wrAcc      = access & pwrite & mapped;
  assign wrCtrl     = wrAcc & (idx == `SPIC_IDX_CTRL) & ~page_q;
  assign wrInterval = wrAcc & (idx == `SPIC_IDX_CTRL) & page_q;
  assign wrStat     = wrAcc & (idx == `SPIC_IDX_STAT);
  assign wrData     = wrAcc & (idx == `SPIC_IDX_DATA);
  assign wrPage     = wrAcc & (idx == `SPIC_IDX_PAGE);

  assign pready  = 1'b1;
  assign pslverr = access & err_q;
  assign prdata  = rdData_q;

  logic [31:0] rdNext;
  always_comb begin
    rdNext = 32'h0000_0000;
    if (aligned) begin
      case (idx)
        `SPIC_IDX_CTRL: rdNext = page_q ? {30'h0000_0000, interval_q} : {24'h00_0000, ctrl_q};
        `SPIC_IDX_STAT: rdNext = {24'h00_0000, done_q, wcol_q, ovf_q, fault_q, faultDis_q, 3'h0};
        `SPIC_IDX_DATA: rdNext = {24'h00_0000, rxBuf_q};
        `SPIC_IDX_PAGE: rdNext = {31'h0000_0000, page_q};
        default:        rdNext = 32'h0000_0000;
      endcase
    end
  end

  // Read data and error are captured in the setup cycle
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      rdData_q <= 32'h0000_0000;
      err_q    <= 1'b0;
    end else if (setup) begin
      rdData_q <= pwrite ? 32'h0000_0000 : rdNext;
      err_q    <= ~mapped;
    end
  end

  // Control, interval and page registers; rate select bits are plain storage
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrl_q     <= `SPIC_CTRL_RST;
      interval_q <= `SPIC_INTERVAL_RST;
      page_q     <= 1'b0;
    end else begin
      if (wrCtrl) begin
        ctrl_q <= pwdata[7:0];
      end
      if (wrInterval) begin
        interval_q <= pwdata[1:0];
      end
      if (wrPage) begin
        page_q <= pwdata[0];
      end
    end
  end

  // Synchronised pin levels and slave completion toggle
  spic_sync #(
    .WIDTH(3)
  ) u_sync (
    .clock  (clock),
    .reset  (reset),
    .asyncIn({doneTog_l, ssNIn, misoIn}),
    .syncOut(syncOut)
  );
  assign misoS    = syncOut[0];
  assign ssNS     = syncOut[1];
  assign doneTogS = syncOut[2];

  logic faultNow, slaveDone, busy, start, wrCollide;
  logic wrap, sampleNow, shiftNow, masterDone;
  assign faultNow   = enabled & master & ~faultDis_q & ~ssNS;
  assign slaveDone  = doneTogS ^ doneSeen_q;
  assign busy       = (state_q != spic_pkg::MST_IDLE);
  assign start      = wrData & enabled & master & ~done_q & ~busy & ~faultNow;
  assign wrCollide  = wrData & (done_q | busy);
  assign wrap       = (state_q == spic_pkg::MST_SHIFT) & (div_q == ($clog2(SCK_HALF+1))'(SCK_HALF - 1));
  assign sampleNow  = wrap & (phase ? edge_q[0] : ~edge_q[0]);
  assign shiftNow   = wrap & ~sampleNow & (edge_q != `SPIC_EDGES_LAST);
  assign masterDone = (state_q == spic_pkg::MST_FINISH);

  // Status flags: hardware set wins over a software clear by writing 0
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      done_q     <= 1'b0;
      wcol_q     <= 1'b0;
      ovf_q      <= 1'b0;
      fault_q    <= 1'b0;
      faultDis_q <= 1'b0;
      doneSeen_q <= 1'b0;
    end else begin
      doneSeen_q <= doneTogS;
      if (masterDone | (slaveDone & ~done_q)) begin
        done_q <= 1'b1;
      end else if (wrStat & ~pwdata[`SPIC_DONE_BIT]) begin
        done_q <= 1'b0;
      end
      if (wrCollide) begin
        wcol_q <= 1'b1;
      end else if (wrStat & ~pwdata[`SPIC_WCOL_BIT]) begin
        wcol_q <= 1'b0;
      end
      if (slaveDone & done_q) begin
        ovf_q <= 1'b1;
      end else if (wrStat & ~pwdata[`SPIC_OVF_BIT]) begin
        ovf_q <= 1'b0;
      end
      if (faultNow) begin
        fault_q <= 1'b1;
      end else if (wrStat & ~pwdata[`SPIC_FAULT_BIT]) begin
        fault_q <= 1'b0;
      end
      if (wrStat) begin
        faultDis_q <= pwdata[`SPIC_FAULT_DIS_BIT];
      end
    end
  end

  // Transmit byte and receive buffer
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      txByte_q <= `SPIC_DATA_RST;
      rxBuf_q  <= `SPIC_DATA_RST;
    end else begin
      if (wrData & ~done_q & ~busy) begin
        txByte_q <= pwdata[7:0];
      end
      if (masterDone) begin
        rxBuf_q <= mRx_q;
      end else if (slaveDone & ~done_q) begin
        rxBuf_q <= sByte_l;
      end
    end
  end

  // Master sequencer
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state_q <= spic_pkg::MST_IDLE;
      div_q   <= '0;
      edge_q  <= 5'h00;
    end else if (~enabled | ~master | faultNow) begin
      state_q <= spic_pkg::MST_IDLE;
      div_q   <= '0;
      edge_q  <= 5'h00;
    end else begin
      case (state_q)
        spic_pkg::MST_IDLE: begin
          div_q  <= '0;
          edge_q <= 5'h00;
          if (start) begin
            state_q <= spic_pkg::MST_SHIFT;
          end
        end
        spic_pkg::MST_SHIFT: begin
          if (wrap) begin
            div_q  <= '0;
            edge_q <= 5'(edge_q + 5'h01);
            if (edge_q == `SPIC_EDGES_LAST) begin
              state_q <= spic_pkg::MST_FINISH;
            end
          end else begin
            div_q <= ($clog2(SCK_HALF+1))'(div_q + 1'b1);
          end
        end
        spic_pkg::MST_FINISH: begin
          state_q <= spic_pkg::MST_IDLE;
        end
        default: begin
          state_q <= spic_pkg::MST_IDLE;
        end
      endcase
    end
  end

  // Master serial clock, data out, receive shift and select
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sck_q    <= 1'b0;
      mosi_q   <= 1'b0;
      outIdx_q <= 3'h0;
      mRx_q    <= 8'h00;
      ssN_q    <= 1'b1;
    end else begin
      if (state_q != spic_pkg::MST_SHIFT) begin
        sck_q <= idlePol;
      end else if (wrap) begin
        sck_q <= ~sck_q;
      end
      if (start) begin
        mosi_q   <= phase ? 1'b0 : pickBit(pwdata[7:0], 3'h0, lowFirst);
        outIdx_q <= phase ? 3'h0 : 3'h1;
        ssN_q    <= 1'b0;
      end else if (shiftNow) begin
        mosi_q   <= pickBit(txByte_q, outIdx_q, lowFirst);
        outIdx_q <= 3'(outIdx_q + 3'h1);
      end
      if (sampleNow) begin
        mRx_q <= shiftIn(mRx_q, misoS, lowFirst);
      end
      if (masterDone | ~busy & ~start) begin
        ssN_q <= 1'b1;
      end
    end
  end

  // Pin drive
  assign sckOut  = sck_q;
  assign sckOe   = enabled & master;
  assign mosiOut = mosi_q;
  assign mosiOe  = enabled & master;
  assign ssNOut  = ssN_q;
  assign ssNOe   = enabled & master & faultDis_q & selectOe;
  assign misoOe  = enabled & ~master & ~ssNS;

  // Slave side on the link clock; sample edge chosen by polarity and phase
  logic sampleClk, frameClr;
  assign sampleClk = linkClock ^ idlePol ^ phase;
  assign frameClr  = reset | ssNIn | ~enabled | master;

  always_ff @(posedge sampleClk or posedge frameClr) begin
    if (frameClr) begin
      sCount_l <= 3'h0;
      sRx_l    <= 8'h00;
    end else begin
      sCount_l <= 3'(sCount_l + 3'h1);
      sRx_l    <= shiftIn(sRx_l, mosiIn, lowFirst);
    end
  end

  always_ff @(posedge sampleClk or posedge reset) begin
    if (reset) begin
      sByte_l   <= 8'h00;
      doneTog_l <= 1'b0;
    end else if (~ssNIn & enabled & ~master & (sCount_l == 3'h7)) begin
      sByte_l   <= shiftIn(sRx_l, mosiIn, lowFirst);
      doneTog_l <= ~doneTog_l;
    end
  end

  assign misoOut = pickBit(txByte_q, sCount_l, lowFirst);

endmodule

// >>> testbench/spic_control_config_checker.sv
// Port-level checks of the SPI control block.
// Assumes control, page and fault-disable bits are shadowed from APB writes.
`timescale 1ns/1ps
`include "spic_map.svh"
module spic_control_config_checker (
  // Clock and reset
  input wire logic                    clock,
  input wire logic                    reset,
  // APB
  input wire logic                    psel,
  input wire logic                    penable,
  input wire logic                    pwrite,
  input wire logic [`SPIC_ADDR_W-1:0] paddr,
  input wire logic [31:0]             pwdata,
  input wire logic                    pslverr,
  // Pins
  input wire logic                    sckOut,
  input wire logic                    sckOe,
  input wire logic                    mosiOe,
  input wire logic                    misoOe,
  input wire logic                    ssNOut,
  input wire logic                    ssNOe
);
  logic [7:0] ctrlQ;
  logic       pageQ;
  logic       disQ;
  logic       sckPrevQ;
  logic [4:0] edgeQ;
  wire  [9:0] idx = paddr[11:2];
  wire        wr  = psel && penable && pwrite && paddr[1:0] == 2'h0;
  wire        mapped = paddr[1:0] == 2'h0 && (idx == `SPIC_IDX_CTRL || idx == `SPIC_IDX_STAT ||
                       idx == `SPIC_IDX_DATA || idx == `SPIC_IDX_PAGE);
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ctrlQ <= 8'h00;
      pageQ <= 1'b0;
      disQ  <= 1'b0;
    end else if (wr) begin
      if (idx == `SPIC_IDX_CTRL && !pageQ) ctrlQ <= pwdata[7:0];
      if (idx == `SPIC_IDX_PAGE) pageQ <= pwdata[0];
      if (idx == `SPIC_IDX_STAT) disQ <= pwdata[3];
    end
  end
  // Serial clock edges seen while slave select is low
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sckPrevQ <= 1'b0;
      edgeQ    <= 5'h00;
    end else begin
      sckPrevQ <= sckOut;
      edgeQ    <= ssNOut ? 5'h00 : edgeQ + 5'(sckOut != sckPrevQ);
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  unit_off_a: assert property (!ctrlQ[6] |-> !sckOe && !mosiOe && !misoOe && !ssNOe)
    else $error("pin driven while unit disabled");
  select_gate_a: assert property (ssNOe == (ctrlQ[7] && ctrlQ[6] && ctrlQ[4] && disQ))
    else $error("select enable wrong for configuration");
  select_gpio_a: assert property (!ctrlQ[7] |-> !ssNOe)
    else $error("select driven with output enable off");
  fault_input_a: assert property (!disQ |-> !ssNOe)
    else $error("select driven while fault detection on");
  master_drive_a: assert property (sckOe == (ctrlQ[6] && ctrlQ[4]) && mosiOe == sckOe)
    else $error("clock or data drive wrong for role");
  slave_miso_a: assert property (misoOe |-> ctrlQ[6] && !ctrlQ[4])
    else $error("miso driven outside slave role");
  sck_idle_a: assert property (sckOe && $past(sckOe, 2) && ssNOut && $past(ssNOut) &&
    ctrlQ[3] == $past(ctrlQ[3], 2) |-> sckOut == ctrlQ[3])
    else $error("serial clock not at idle level");
  sck_framed_a: assert property ($changed(sckOut) && sckOe && $past(sckOe, 2) &&
    ctrlQ[3] == $past(ctrlQ[3], 2) |-> !$past(ssNOut))
    else $error("serial clock moved outside a frame");
  byte_edges_a: assert property ($rose(ssNOut) && sckOe && disQ |-> edgeQ == 5'h10)
    else $error("frame did not hold sixteen clock edges");
  bus_error_a: assert property (psel && penable |-> pslverr == !mapped)
    else $error("error response wrong for address");
endmodule

bind spic_control_config spic_control_config_checker u_spic_control_config_checker (
  .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pslverr(pslverr), .sckOut(sckOut), .sckOe(sckOe), .mosiOe(mosiOe),
  .misoOe(misoOe), .ssNOut(ssNOut), .ssNOe(ssNOe));

// >>> testbench/spic_slave_model.sv
// External SPI slave facing the block in master role.
// Assumes the bench gives it the mode bits and the byte it answers with.
`timescale 1ns/1ps
module spic_slave_model (
  // Mode
  input wire logic       idlePol,
  input wire logic       samplePhase,
  input wire logic       lowFirst,
  input wire logic [7:0] txByte,
  // Pins
  input wire logic       sck,
  input wire logic       mosi,
  input wire logic       ssN,
  output logic           miso,
  // Received byte
  output logic [7:0]     rxByte,
  output logic           gotByte
);
  int n;
  wire smp = sck ^ idlePol ^ samplePhase;
  function automatic int pos(input int i);
    return lowFirst ? i : 7 - i;
  endfunction
  initial begin
    n = 0;
    miso = 1'b0;
    rxByte = 8'h00;
    gotByte = 1'b0;
  end
  always @(negedge ssN) begin
    n = 0;
    miso = txByte[pos(0)];
  end
  always @(posedge smp) if (!ssN && n < 8) begin
    rxByte[pos(n)] = mosi;
    n = n + 1;
  end
  // Shift on the other edge; the first bit is out from select
  always @(negedge smp) if (!ssN && n > 0 && n < 8) miso = txByte[pos(n)];
  // Only a whole byte is reported; select settling high at start-up is no frame
  always @(posedge ssN) begin
    miso = ~miso;
    if (n == 8) begin
      gotByte = 1'b1;
      #1 gotByte = 1'b0;
    end
  end
endmodule

// >>> testbench/spic_control_config_bench.sv
// Self-checking bench of the SPI control block with a slave model.
// Assumes the port checker is bound to the design.
`timescale 1ns/1ps
`include "spic_map.svh"
module spic_control_config_bench;
  localparam logic [11:0] A_CTRL = {`SPIC_IDX_CTRL, 2'b00};
  localparam logic [11:0] A_STAT = {`SPIC_IDX_STAT, 2'b00};
  localparam logic [11:0] A_DATA = {`SPIC_IDX_DATA, 2'b00};
  localparam logic [11:0] A_PAGE = {`SPIC_IDX_PAGE, 2'b00};
  logic        clock, reset, psel, penable, pwrite, linkClk, mosiIn, ssDrv, err, got;
  logic        pready, pslverr, sckOut, sckOe, mosiOut, mosiOe, misoIn, misoOut, misoOe, ssNOut, ssNOe;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, v, w;
  logic [7:0]  cfg, txB, rxB, s;
  logic [7:0]  expQ[$];
  int          miscompares = 0;
  int          n_checks = 0;
  int          cyc = 0;
  wire         ssLine = ssNOe ? ssNOut : ssDrv;
  spic_control_config #(.SCK_HALF(4)) u_spic_control_config (.clock(clock), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .linkClock(linkClk), .sckOut(sckOut), .sckOe(sckOe),
    .mosiIn(mosiIn), .mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(misoIn), .misoOut(misoOut),
    .misoOe(misoOe), .ssNIn(ssLine), .ssNOut(ssNOut), .ssNOe(ssNOe));
  spic_slave_model u_spic_slave_model (.idlePol(cfg[3]), .samplePhase(cfg[2]), .lowFirst(cfg[5]),
    .txByte(txB), .sck(sckOut), .mosi(mosiOut), .ssN(ssNOe ? ssNOut : 1'b1), .miso(misoIn),
    .rxByte(rxB), .gotByte(got));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wait_done();
    do apb(1'b0, A_STAT, 32'h0); while (rd[7] !== 1'b1);
  endtask
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  always @(posedge clock) if (++cyc > 20000) begin
    miscompares++;
    test_done();
  end
  // Each byte the slave model completes is matched against the oldest note
  always @(posedge got) begin
    if (expQ.size() == 0) check("unexpected frame", 32'h1, 32'h0);
    else check("slave received", {24'h0, rxB}, {24'h0, expQ.pop_front()});
  end
  initial begin
    reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0;
    linkClk = 1'b0; mosiIn = 1'b0; ssDrv = 1'b1; cfg = 8'h00; txB = 8'h00;
    void'($urandom(32'h319E));
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    apb(1'b0, A_CTRL, 32'h0); check("control reset", rd, 32'h0);
    apb(1'b0, 12'h3CE, 32'h0); check("unaligned error", {31'h0, err}, 32'h1);
    v = $urandom;
    apb(1'b1, A_CTRL, v); apb(1'b0, A_CTRL, 32'h0); check("control rw", rd, {24'h0, v[7:0]});
    apb(1'b1, A_PAGE, 32'h1); apb(1'b1, A_CTRL, 32'hFF);
    apb(1'b0, A_CTRL, 32'h0); check("page one word", rd, 32'h3);
    apb(1'b1, A_PAGE, 32'h0);
    apb(1'b0, A_CTRL, 32'h0); check("page zero kept", rd, {24'h0, v[7:0]});
    $display("register test done");
    apb(1'b1, A_STAT, 32'h8);
    // Every order, polarity and phase in master role
    for (int m = 0; m < 8; m++) begin
      txB = 8'($urandom);
      cfg = {2'b11, m[2], 1'b1, m[1:0], 2'b00};
      apb(1'b1, A_CTRL, {24'h0, cfg});
      v = $urandom;
      expQ.push_back(v[7:0]);
      apb(1'b1, A_DATA, v);
      wait_done();
      apb(1'b0, A_DATA, 32'h0); check("master received", rd, {24'h0, txB});
      if (m < 7) apb(1'b1, A_STAT, 32'h8);
    end
    apb(1'b1, A_DATA, 32'hA5);
    repeat (80) @(posedge clock);
    apb(1'b0, A_STAT, 32'h0); check("collision status", rd, 32'hC8);
    apb(1'b1, A_STAT, 32'h8);
    cfg = 8'h50;
    apb(1'b1, A_CTRL, {24'h0, cfg}); apb(1'b1, A_DATA, $urandom); wait_done();
    $display("master test done");
    apb(1'b1, A_STAT, 32'h0);
    @(posedge clock) ssDrv <= 1'b0;
    repeat (4) @(posedge clock);
    apb(1'b0, A_STAT, 32'h0); check("role fault", rd, 32'h10);
    ssDrv <= 1'b1;
    apb(1'b1, A_STAT, 32'h0); apb(1'b0, A_STAT, 32'h0); check("fault cleared", rd, 32'h0);
    $display("fault test done");
    // Slave role on the link clock: low bit first in mode 0, then high bit first with polarity 1, phase 1
    for (int k = 0; k < 2; k++) begin
      cfg = k ? 8'h4C : 8'h60;
      apb(1'b1, A_CTRL, {24'h0, cfg});
      linkClk = cfg[3];
      v = $urandom;
      w = $urandom;
      apb(1'b1, A_DATA, v);
      @(posedge clock) ssDrv <= 1'b0;
      repeat (4) @(posedge clock);
      // Offset keeps link clock edges away from system clock edges
      #13;
      for (int i = 0; i < 8; i++) begin
        mosiIn <= w[cfg[5] ? i : 7 - i];
        #80 s[cfg[5] ? i : 7 - i] = misoOut;
        linkClk = ~cfg[3];
        #80 linkClk = cfg[3];
      end
      mosiIn <= ~mosiIn;
      @(posedge clock) ssDrv <= 1'b1;
      wait_done();
      apb(1'b0, A_DATA, 32'h0); check("slave role received", rd, {24'h0, w[7:0]});
      check("slave role sent", {24'h0, s}, {24'h0, v[7:0]});
      apb(1'b1, A_STAT, 32'h0);
    end
    check("frames left", expQ.size(), 32'h0);
    $display("slave test done");
    test_done();
  end
endmodule
